// [core/rdsl_defs.svh]
`ifndef RDSL_DEFS_SVH
`define RDSL_DEFS_SVH

// Register byte addresses on the APB (one aligned word each).
`define RDSL_OFF_CTRL        12'h000
`define RDSL_OFF_STATUS      12'h004
`define RDSL_OFF_PROG_CNT    12'h008
`define RDSL_OFF_VECTOR      12'h00C
`define RDSL_OFF_MEM_SIZE    12'h010
`define RDSL_OFF_XRAM_SIZE   12'h014
`define RDSL_OFF_WDT         12'h018
`define RDSL_OFF_RAM_DATA    12'h01C
`define RDSL_OFF_RAM_ADDR    12'h020
`define RDSL_OFF_BANK_BASE   12'h100
`define RDSL_NUM_BANK        44

// Control and status fields.
`define RDSL_CTRL_STANDBY    0
`define RDSL_CTRL_SWRST      1
`define RDSL_STAT_BUSY       0
`define RDSL_STAT_STANDBY    1
`define RDSL_STAT_VEC_DONE   2

// Reset values.
`define RDSL_MEM_SIZE_RST    8'hCF
`define RDSL_XRAM_SIZE_RST   8'h0C
`define RDSL_WDT_RST_A       8'h1A
`define RDSL_WDT_RST_B       8'h9A
`define RDSL_ONES_RST        8'hFF
`define RDSL_ZERO_RST        8'h00
`define RDSL_ASYNC_MODE_RST  8'h01
`define RDSL_VECTOR_LO       16'h0000
`define RDSL_VECTOR_HI       16'h0001

// Oscillation stabilization wait, in ns and in cycles at 4 ns.
`define RDSL_CLK_PERIOD_NS   4
`define RDSL_OSC_WAIT_NS     400
`define RDSL_OSC_WAIT_CYC    ((`RDSL_OSC_WAIT_NS + `RDSL_CLK_PERIOD_NS - 1) / `RDSL_CLK_PERIOD_NS)
`define RDSL_RAM_DEPTH       16

`endif

// [core/rdsl_pkg.sv]
package rdsl_pkg;
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_VEC_LO,
    ST_VEC_HI,
    ST_RUN
  } rdsl_state_t;
endpackage : rdsl_pkg

// [core/rdsl_top.sv]
`include "rdsl_defs.svh"

module rdsl_top (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  // Combined reset request and option bit.
  input  wire logic        i_reset_req,
  input  wire logic        i_wdt_option,
  // Program memory vector fetch.
  input  wire logic [7:0]  i_prog_data,
  output logic      [15:0] o_prog_addr,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core state.
  output logic      [15:0] o_program_counter,
  output logic             o_run
);

  // Bank slots: 0..4 port directions, 5..11 wide timer bytes and controls,
  // 12..19 narrow timers, 20..23 interval timer, 24..30 async serial,
  // 31..34 clocked serial, 35..39 usb_interrupt_clear, 40..41 usb status and
  // mask, 42 usb control endpoint length, 43 usb setup.
  localparam int NB = `RDSL_NUM_BANK;

  logic [1:0]            rst_sync_q;
  logic                  rst_q;
  logic                  opt_s1_q;
  logic                  opt_s2_q;
  logic [7:0]            bank_q [NB];
  logic [7:0]            ram_q [`RDSL_RAM_DEPTH];
  logic [3:0]            ram_addr_q;
  logic [7:0]            mem_size_q;
  logic [7:0]            xram_size_q;
  logic [7:0]            wdt_q;
  logic                  standby_q;
  logic                  reset_in_standby_q;
  logic                  swrst_q;
  logic [15:0]           prog_cnt_q;
  logic [15:0]           vec_q;
  logic [7:0]            wait_cnt_q;
  logic [7:0]            usb_ctrl_read_q;
  rdsl_pkg::rdsl_state_t state_q;
  logic                  wr_en;

  // Writes act only in the access phase, so a setup cycle never changes state.
  assign wr_en = psel && penable && pwrite;

  // Reset request and option bit come from another domain: two flops each.
  // Only the second flop of each pair is read by the logic below.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_q <= 2'h0;
      opt_s1_q   <= 1'b0;
      opt_s2_q   <= 1'b0;
    end else if (i_clk_en) begin
      rst_sync_q <= {rst_sync_q[0], i_reset_req};
      opt_s1_q   <= i_wdt_option;
      opt_s2_q   <= opt_s1_q;
    end
  end

  // A software reset joins the synchronised request so both take one path.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_q <= 1'b1;
    end else if (i_clk_en) begin
      rst_q <= rst_sync_q[1] || swrst_q;
    end
  end

  // The defaults are loaded by a clocked process so that a standby reset can
  // spare the RAM; an asynchronous clear would wipe it.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      standby_q          <= 1'b0;
      reset_in_standby_q <= 1'b0;
      swrst_q            <= 1'b0;
    end else if (i_clk_en) begin
      swrst_q <= wr_en && paddr == `RDSL_OFF_CTRL && pwdata[`RDSL_CTRL_SWRST];
      // Standby is held for the whole reset so that the flag reports this
      // reset only, and is dropped once the wait after reset has begun.
      if (rst_q) begin
        reset_in_standby_q <= standby_q;
      end else if (wr_en && paddr == `RDSL_OFF_CTRL) begin
        standby_q          <= pwdata[`RDSL_CTRL_STANDBY];
        reset_in_standby_q <= 1'b0;
      end else if (state_q == rdsl_pkg::ST_WAIT) begin
        standby_q          <= 1'b0;
      end
    end
  end

  // Register defaults.
  generate
    for (genvar g = 0; g < NB; g++) begin : g_bank
      localparam logic [7:0] RST_V =
        (g < 5) ? `RDSL_ONES_RST :
        (g == 24 || g == 25 || g == 30) ? `RDSL_ONES_RST :
        (g == 26) ? `RDSL_ASYNC_MODE_RST :
        (g >= 35 && g < 40) ? `RDSL_ONES_RST :
        `RDSL_ZERO_RST;
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          bank_q[g] <= RST_V;
        end else if (i_clk_en) begin
          if (rst_q) begin
            bank_q[g] <= RST_V;
          end else if (wr_en && paddr == 12'(`RDSL_OFF_BANK_BASE + 4 * g)) begin
            bank_q[g] <= pwdata[7:0];
          end
        end
      end
      a_bank_default: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_clk_en && rst_q) |=> bank_q[g] == RST_V) else $error("bank default lost");
    end
  endgenerate

  // RAM is left as it was across any reset; no clear is ever applied.
  // The cost is that a power-up leaves it unknown until software fills it.
  always_ff @(posedge i_clk) begin
    if (i_clk_en && !rst_q && wr_en && paddr == `RDSL_OFF_RAM_DATA) begin
      ram_q[ram_addr_q] <= pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ram_addr_q <= 4'h0;
    end else if (i_clk_en && wr_en && paddr == `RDSL_OFF_RAM_ADDR) begin
      ram_addr_q <= pwdata[3:0];
    end
  end

  // USB control endpoint read holds whatever it had; reset leaves it alone.
  always_ff @(posedge i_clk) begin
    if (i_clk_en && wr_en && paddr == `RDSL_OFF_BANK_BASE + 12'h0B0) begin
      usb_ctrl_read_q <= pwdata[7:0];
    end
  end

  // Both size selects come up at fixed values whatever memory is fitted;
  // software has to set them to the real sizes after every reset.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mem_size_q  <= `RDSL_MEM_SIZE_RST;
      xram_size_q <= `RDSL_XRAM_SIZE_RST;
    end else if (i_clk_en) begin
      if (rst_q) begin
        mem_size_q  <= `RDSL_MEM_SIZE_RST;
        xram_size_q <= `RDSL_XRAM_SIZE_RST;
      end else if (wr_en && paddr == `RDSL_OFF_MEM_SIZE) begin
        mem_size_q  <= pwdata[7:0];
      end else if (wr_en && paddr == `RDSL_OFF_XRAM_SIZE) begin
        xram_size_q <= pwdata[7:0];
      end
    end
  end

  // The option bit is looked at only while reset lasts, never while running.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wdt_q <= `RDSL_WDT_RST_A;
    end else if (i_clk_en) begin
      if (rst_q) begin
        wdt_q <= opt_s2_q ? `RDSL_WDT_RST_B : `RDSL_WDT_RST_A;
      end else if (wr_en && paddr == `RDSL_OFF_WDT) begin
        wdt_q <= pwdata[7:0];
      end
    end
  end

  // Vector fetch sequencer.
  // The program counter is not cleared by a reset request: it is written only
  // from the vector or by software while running, so its value during the wait does not matter.
  // Program memory answers in the same cycle, so each byte takes one state.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q     <= rdsl_pkg::ST_WAIT;
      wait_cnt_q  <= 8'h00;
      prog_cnt_q  <= 16'h0000;
      vec_q       <= 16'h0000;
      o_prog_addr <= `RDSL_VECTOR_LO;
      o_run       <= 1'b0;
    end else if (i_clk_en) begin
      if (rst_q) begin
        state_q     <= rdsl_pkg::ST_WAIT;
        wait_cnt_q  <= 8'h00;
        o_prog_addr <= `RDSL_VECTOR_LO;
        o_run       <= 1'b0;
      end else begin
        unique case (state_q)
          rdsl_pkg::ST_WAIT: begin
            wait_cnt_q <= wait_cnt_q + 8'h01;
            if (wait_cnt_q == 8'(`RDSL_OSC_WAIT_CYC - 1)) begin
              state_q     <= rdsl_pkg::ST_VEC_LO;
              o_prog_addr <= `RDSL_VECTOR_LO;
            end
          end
          rdsl_pkg::ST_VEC_LO: begin
            vec_q[7:0]  <= i_prog_data;
            o_prog_addr <= `RDSL_VECTOR_HI;
            state_q     <= rdsl_pkg::ST_VEC_HI;
          end
          rdsl_pkg::ST_VEC_HI: begin
            vec_q[15:8] <= i_prog_data;
            prog_cnt_q  <= {i_prog_data, vec_q[7:0]};
            state_q     <= rdsl_pkg::ST_RUN;
            o_run       <= 1'b1;
          end
          rdsl_pkg::ST_RUN: begin
            if (wr_en && paddr == `RDSL_OFF_PROG_CNT) begin
              prog_cnt_q <= pwdata[15:0];
            end
          end
        endcase
      end
    end
  end

  assign o_program_counter = prog_cnt_q;

  // Checks on the sequencer and on the defaults it guards.
  a_vector_before_run: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_run) |-> prog_cnt_q == vec_q)
    else $error("run began without vector");
  a_run_after_vec: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_run) |-> $past(state_q) == rdsl_pkg::ST_VEC_HI)
    else $error("run began before high byte");
  a_vec_lo_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_q == rdsl_pkg::ST_VEC_LO |-> o_prog_addr == `RDSL_VECTOR_LO)
    else $error("low vector byte address wrong");
  a_vec_hi_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_q == rdsl_pkg::ST_VEC_HI |-> o_prog_addr == `RDSL_VECTOR_HI)
    else $error("high vector byte address wrong");
  a_size_after_rst: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(rst_q) |-> mem_size_q == `RDSL_MEM_SIZE_RST && xram_size_q == `RDSL_XRAM_SIZE_RST)
    else $error("size select default");
  a_hold_in_wait: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state_q == rdsl_pkg::ST_WAIT && !rst_q && i_clk_en && !wr_en) |=> $stable(mem_size_q) && $stable(wdt_q))
    else $error("state moved during wait");
  a_run_low_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_clk_en && rst_q) |=> !o_run)
    else $error("running during reset");
  a_wait_cnt_cap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_q == rdsl_pkg::ST_WAIT |-> wait_cnt_q < 8'(`RDSL_OSC_WAIT_CYC))
    else $error("wait counter overran");
  a_wdt_choice: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_clk_en && rst_q) |=> wdt_q == ($past(opt_s2_q) ? `RDSL_WDT_RST_B : `RDSL_WDT_RST_A))
    else $error("watchdog default wrong");
  a_standby_mark: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_clk_en && rst_q && standby_q) |=> reset_in_standby_q)
    else $error("standby reset not reported");
  a_swrst_enter: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_clk_en && swrst_q) |=> rst_q)
    else $error("software reset not taken");

  // APB answers with no wait state; unmapped offsets read zero and flag error.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (i_clk_en) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        if (paddr == `RDSL_OFF_STATUS) begin
          prdata[2:0] <= {state_q == rdsl_pkg::ST_RUN, reset_in_standby_q, rst_q};
        end else if (paddr == `RDSL_OFF_PROG_CNT) begin
          prdata[15:0] <= prog_cnt_q;
        end else if (paddr == `RDSL_OFF_VECTOR) begin
          prdata[15:0] <= vec_q;
        end else if (paddr == `RDSL_OFF_MEM_SIZE) begin
          prdata[7:0] <= mem_size_q;
        end else if (paddr == `RDSL_OFF_XRAM_SIZE) begin
          prdata[7:0] <= xram_size_q;
        end else if (paddr == `RDSL_OFF_WDT) begin
          prdata[7:0] <= wdt_q;
        end else if (paddr == `RDSL_OFF_RAM_DATA) begin
          prdata[7:0] <= ram_q[ram_addr_q];
        end else if (paddr == `RDSL_OFF_RAM_ADDR) begin
          prdata[3:0] <= ram_addr_q;
        end else if (paddr == `RDSL_OFF_BANK_BASE + 12'h0B0) begin
          prdata[7:0] <= usb_ctrl_read_q;
        end else if (paddr >= `RDSL_OFF_BANK_BASE && paddr < 12'(`RDSL_OFF_BANK_BASE + 4 * NB)
                     && paddr[1:0] == 2'h0) begin
          prdata[7:0] <= bank_q[6'(paddr[11:2] - 10'h040)];
        end else if (paddr != `RDSL_OFF_CTRL) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // The answer is a one-cycle pulse: a master that holds penable high
  // past it must not see a second acknowledge.
  a_pready_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_clk_en && pready) |=> !pready)
    else $error("ready held for two cycles");
  a_slverr_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");

endmodule : rdsl_top

// [verification/rdsl_top_test.sv]
`include "rdsl_defs.svh"

module rdsl_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk, i_rst_b, i_clk_en, i_reset_req, i_wdt_option;
  logic        psel, penable, pwrite, pready, pslverr, o_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] o_prog_addr, o_program_counter, vec;
  wire  [7:0]  i_prog_data = (o_prog_addr == `RDSL_VECTOR_LO) ? vec[7:0] : vec[15:8];
  logic        er;
  int          err_count, compares, cyc;

  rdsl_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_reset_req(i_reset_req),
    .i_wdt_option(i_wdt_option), .i_prog_data(i_prog_data), .o_prog_addr(o_prog_addr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .o_program_counter(o_program_counter), .o_run(o_run));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // A cycle ceiling well above the thousand or so cycles the tests need.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Expected reset value of each bank slot, from the slot map of the block.
  function automatic logic [31:0] bank_exp(input int i);
    if (i < 5 || i == 24 || i == 25 || i == 30 || (i >= 35 && i < 40)) return 32'h0000_00FF;
    if (i == 26) return 32'h0000_0001;
    return 32'h0000_0000;
  endfunction : bank_exp

  function automatic logic [31:0] wdt_exp(input logic opt);
    return opt ? 32'h0000_009A : 32'h0000_001A;
  endfunction : wdt_exp

  // One APB transfer; waits for pready however long the slave takes.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rd, exp);
    check("pslverr", {31'h0, er}, 32'h0);
  endtask : rchk

  task automatic bank_defaults();
    for (int i = 0; i < `RDSL_NUM_BANK; i++) begin
      rchk("bank_default", 12'(`RDSL_OFF_BANK_BASE + 4 * i), bank_exp(i));
    end
  endtask : bank_defaults

  // Fills every slot with a random byte so a later reset has work to undo.
  task automatic bank_scramble();
    logic [31:0] d;
    for (int i = 0; i < `RDSL_NUM_BANK; i++) begin
      d = {24'h0, 8'($urandom)};
      apb(1'b1, 12'(`RDSL_OFF_BANK_BASE + 4 * i), d);
      rchk("bank_write", 12'(`RDSL_OFF_BANK_BASE + 4 * i), d);
    end
  endtask : bank_scramble

  // Waits for the vector fetch and checks the loaded program counter.
  task automatic wait_run();
    while (o_run !== 1'b1) @(posedge i_clk);
    check("program_counter", {16'h0, o_program_counter}, {16'h0, vec});
  endtask : wait_run

  task automatic req_reset(input logic opt);
    @(posedge i_clk);
    vec <= 16'($urandom);
    i_wdt_option <= opt;
    i_reset_req <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_reset_req <= 1'b0;
    check("run_low", {31'h0, o_run}, 32'h0);
    rchk("mem_size_in_wait", `RDSL_OFF_MEM_SIZE, 32'h0000_00CF);
    wait_run();
  endtask : req_reset

  initial begin
    logic [31:0] d;
    i_rst_b = 1'b0;
    i_clk_en = 1'b1;
    i_reset_req = 1'b0;
    i_wdt_option = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    vec = 16'h1234;
    void'($urandom(32'h2e56));
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    wait_run();
    rchk("mem_size", `RDSL_OFF_MEM_SIZE, 32'h0000_00CF);
    rchk("xram_size", `RDSL_OFF_XRAM_SIZE, 32'h0000_000C);
    rchk("wdt_a", `RDSL_OFF_WDT, wdt_exp(1'b0));
    bank_defaults();
    bank_scramble();
    $display("test power-up done");
    apb(1'b1, `RDSL_OFF_MEM_SIZE, 32'h0000_00C4);
    apb(1'b1, `RDSL_OFF_XRAM_SIZE, 32'h0000_0008);
    rchk("mem_size_sw", `RDSL_OFF_MEM_SIZE, 32'h0000_00C4);
    rchk("xram_size_sw", `RDSL_OFF_XRAM_SIZE, 32'h0000_0008);
    req_reset(1'b1);
    rchk("mem_size_back", `RDSL_OFF_MEM_SIZE, 32'h0000_00CF);
    rchk("xram_size_back", `RDSL_OFF_XRAM_SIZE, 32'h0000_000C);
    rchk("wdt_b", `RDSL_OFF_WDT, wdt_exp(1'b1));
    apb(1'b0, `RDSL_OFF_STATUS, 32'h0);
    check("standby_flag_clear", {31'h0, rd[`RDSL_STAT_STANDBY]}, 32'h0);
    bank_defaults();
    $display("test memory size reload done");
    apb(1'b1, `RDSL_OFF_MEM_SIZE, 32'h0000_00C4);
    apb(1'b1, `RDSL_OFF_CTRL, 32'h0000_0002);
    repeat (3) @(posedge i_clk);
    check("run_low_sw", {31'h0, o_run}, 32'h0);
    wait_run();
    rchk("mem_size_sw_rst", `RDSL_OFF_MEM_SIZE, 32'h0000_00CF);
    rchk("wdt_sw_rst", `RDSL_OFF_WDT, wdt_exp(1'b1));
    $display("test software reset done");
    d = {24'h0, 8'($urandom)};
    apb(1'b1, `RDSL_OFF_RAM_ADDR, 32'h0000_0005);
    apb(1'b1, `RDSL_OFF_RAM_DATA, d);
    apb(1'b1, `RDSL_OFF_CTRL, 32'h0000_0001);
    req_reset(1'b0);
    apb(1'b1, `RDSL_OFF_RAM_ADDR, 32'h0000_0005);
    rchk("ram_kept", `RDSL_OFF_RAM_DATA, d);
    apb(1'b0, `RDSL_OFF_STATUS, 32'h0);
    check("standby_flag", {31'h0, rd[`RDSL_STAT_STANDBY]}, 32'h1);
    $display("test standby retention done");
    apb(1'b0, 12'h024, 32'h0);
    check("unmapped_err", {31'h0, er}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    $display("test unmapped done");
    finish_test();
  end
endmodule : rdsl_top_test
